// ===== hw/oad_decoder.v
// operand address decoder: fetches an instruction and resolves its operand addresses
// Function
// - byte bit one selects 8-bit operand, zero selects 16-bit word.
// - two-bit type fields select addressing mode for source and destination.
// - register fields name workspace registers 0 to 15.
// - type 00 uses the named workspace register itself.
// - byte access in direct register mode hits the register's left byte.
// - destination fields sit above source fields in two-operand words.
// - opcode 110 with byte clear decodes as word move.
// - type 01 uses register content as operand address.
// - type 11 is indirect, then register grows by one or two.
// - type 10 with register 0 uses next word as address.
// - both symbolic: source from first extension word, destination from second.
// - type 10 nonzero register adds index register to extension word.
// - jump target is program counter plus twice signed displacement.
// - count field gives shift positions or serial bit-I/O transfer count.
// - word operand addresses are always even; direct-mode addresses are wp_in plus twice n and are not forced even.
// - instructions are one, two or three words long.
// - workspace register n lies at workspace pointer plus twice n.
`timescale 1ns/10ps
`include "oad_regs.vh"
module oad_decoder (
	input wire sys_clk_in,
	input wire rst_in,
	input wire start_in,
	input wire [15:0] pc_in,
	input wire [15:0] wp_in,
	input wire mem_ack_in,
	input wire [15:0] mem_rdata_in,
	output reg mem_req_out,
	output reg mem_we_out,
	output reg [15:0] mem_addr_out,
	output reg [15:0] mem_wdata_out,
	output reg busy_out,
	output reg done_out,
	output reg [15:0] instr_out,
	output reg [1:0] instr_len_out,
	output reg byte_op_out,
	output reg move_word_op_out,
	output reg [1:0] src_mode_out,
	output reg [3:0] source_reg_field_out,
	output reg [1:0] dst_mode_out,
	output reg [3:0] dest_reg_field_out,
	output reg src_valid_out,
	output reg dst_valid_out,
	output reg [15:0] src_ea_out,
	output reg [15:0] dst_ea_out,
	output reg [15:0] jump_target_out,
	output reg [3:0] count_out,
	output reg [15:0] next_pc_out
);
	localparam S_IDLE = 4'h0;
	localparam S_FETCH = 4'h1;
	localparam S_HOLD = 4'h2;
	localparam S_DECODE = 4'h3;
	localparam S_OPER = 4'h4;
	localparam S_IND = 4'h5;
	localparam S_INC = 4'h6;
	localparam S_EXT = 4'h7;
	localparam S_IDX = 4'h8;
	localparam S_NEXT = 4'h9;

	reg [3:0] state;
	reg [15:0] pc_r;
	reg cur_dst;
	reg has_dst;
	reg [15:0] ea_r;
	reg [15:0] ext_r;
	reg [1:0] words;
	wire [15:0] ir;

	function [15:0] reg_addr;
		input [15:0] wp;
		input [3:0] n;
		begin
			reg_addr = wp + {11'h000, n, 1'b0};
		end
	endfunction

	// indirect, autoincrement, symbolic and indexed word operands never land on an odd address
	function [15:0] align_ea;
		input [15:0] a;
		input is_byte;
		begin
			align_ea = is_byte ? a : {a[15:1], 1'b0};
		end
	endfunction

	// instruction written back here so extension words stay with it
	oad_ibuf u_ibuf (
		.sys_clk_in(sys_clk_in),
		.wr_en_in(mem_req_out & mem_ack_in & ~mem_we_out),
		.wr_idx_in(words),
		.wr_data_in(mem_rdata_in),
		.rd_idx_in(2'h0),
		.rd_data_out(ir)
	);

	// mode and register follow the operand being resolved
	wire [1:0] cur_mode = cur_dst ? dst_mode_out : src_mode_out;
	wire [3:0] cur_reg = cur_dst ? dest_reg_field_out : source_reg_field_out;
	wire [15:0] cur_reg_addr = reg_addr(wp_in, cur_reg);
	wire [15:0] step = byte_op_out ? `OAD_BYTE_STEP : `OAD_WORD_STEP;

	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			state <= S_IDLE;
			pc_r <= 16'h0000;
			cur_dst <= 1'b0;
			has_dst <= 1'b0;
			ea_r <= 16'h0000;
			ext_r <= 16'h0000;
			words <= 2'h0;
			mem_req_out <= 1'b0;
			mem_we_out <= 1'b0;
			mem_addr_out <= 16'h0000;
			mem_wdata_out <= 16'h0000;
			busy_out <= 1'b0;
			done_out <= 1'b0;
			instr_out <= 16'h0000;
			instr_len_out <= 2'h0;
			byte_op_out <= 1'b0;
			move_word_op_out <= 1'b0;
			src_mode_out <= 2'h0;
			source_reg_field_out <= 4'h0;
			dst_mode_out <= 2'h0;
			dest_reg_field_out <= 4'h0;
			src_valid_out <= 1'b0;
			dst_valid_out <= 1'b0;
			src_ea_out <= 16'h0000;
			dst_ea_out <= 16'h0000;
			jump_target_out <= 16'h0000;
			count_out <= 4'h0;
			next_pc_out <= 16'h0000;
		end else begin
			done_out <= 1'b0;
			case (state)
			S_IDLE: begin
				if (start_in) begin
					busy_out <= 1'b1;
					pc_r <= pc_in;
					words <= 2'h0;
					mem_req_out <= 1'b1;
					mem_we_out <= 1'b0;
					mem_addr_out <= pc_in;
					state <= S_FETCH;
				end
			end
			S_FETCH: begin
				if (mem_ack_in) begin
					mem_req_out <= 1'b0;
					pc_r <= pc_r + `OAD_WORD_STEP;
					words <= words + 2'h1;
					state <= S_HOLD;
				end
			end
			// buffer read is registered, so wait one cycle
			S_HOLD: begin
				state <= S_DECODE;
			end
			S_DECODE: begin
				instr_out <= ir;
				byte_op_out <= ir[`OAD_BYTE_BIT];
				move_word_op_out <= (ir[`OAD_OPC_HI:`OAD_OPC_LO] == `OAD_MOVE_OPC) & ~ir[`OAD_BYTE_BIT];
				dst_mode_out <= ir[`OAD_TD_HI:`OAD_TD_LO];
				dest_reg_field_out <= ir[`OAD_DR_HI:`OAD_DR_LO];
				src_mode_out <= ir[`OAD_TS_HI:`OAD_TS_LO];
				source_reg_field_out <= ir[`OAD_SR_HI:`OAD_SR_LO];
				// pc already points past the instruction
				jump_target_out <= pc_r + {{7{ir[7]}}, ir[7:0], 1'b0};
				// shift count or serial bit-I/O count
				count_out <= (ir[15:12] == 4'h0 && ir[15:8] >= `OAD_FMT5_TOP) ?
					ir[`OAD_SHIFT_CNT_HI:`OAD_SHIFT_CNT_LO] : ir[`OAD_CRU_CNT_HI:`OAD_CRU_CNT_LO];
				src_valid_out <= 1'b0;
				dst_valid_out <= 1'b0;
				cur_dst <= 1'b0;
				// only dual-operand words carry a destination
				has_dst <= ir[15:14] != 2'h0;
				if (instr_is_operand(ir)) begin
					state <= S_OPER;
				end else begin
					state <= S_NEXT;
				end
			end
			S_OPER: begin
				case (cur_mode)
				`OAD_MODE_DIRECT: begin
					// byte access keeps even address, the left byte
					ea_r <= cur_reg_addr;
					state <= S_NEXT;
				end
				`OAD_MODE_SYMBOLIC: begin
					// source first, so it takes the earlier word
					mem_req_out <= 1'b1;
					mem_we_out <= 1'b0;
					mem_addr_out <= pc_r;
					state <= S_EXT;
				end
				default: begin
					mem_req_out <= 1'b1;
					mem_we_out <= 1'b0;
					mem_addr_out <= cur_reg_addr;
					state <= S_IND;
				end
				endcase
			end
			S_IND: begin
				if (mem_ack_in) begin
					ea_r <= align_ea(mem_rdata_in, byte_op_out);
					if (cur_mode == `OAD_MODE_AUTOINC) begin
						// bump register by one or two
						mem_we_out <= 1'b1;
						mem_wdata_out <= mem_rdata_in + step;
						state <= S_INC;
					end else begin
						mem_req_out <= 1'b0;
						state <= S_NEXT;
					end
				end
			end
			S_INC: begin
				if (mem_ack_in) begin
					mem_req_out <= 1'b0;
					mem_we_out <= 1'b0;
					state <= S_NEXT;
				end
			end
			S_EXT: begin
				if (mem_ack_in) begin
					pc_r <= pc_r + `OAD_WORD_STEP;
					words <= words + 2'h1;
					if (cur_reg == 4'h0) begin
						mem_req_out <= 1'b0;
						ea_r <= align_ea(mem_rdata_in, byte_op_out);
						state <= S_NEXT;
					end else begin
						ext_r <= mem_rdata_in;
						mem_addr_out <= cur_reg_addr;
						state <= S_IDX;
					end
				end
			end
			S_IDX: begin
				if (mem_ack_in) begin
					mem_req_out <= 1'b0;
					ea_r <= align_ea(ext_r + mem_rdata_in, byte_op_out);
					state <= S_NEXT;
				end
			end
			S_NEXT: begin
				if (cur_dst) begin
					dst_ea_out <= ea_r;
					dst_valid_out <= 1'b1;
				end else if (instr_is_operand(instr_out)) begin
					src_ea_out <= ea_r;
					src_valid_out <= 1'b1;
				end
				if (!cur_dst && has_dst) begin
					cur_dst <= 1'b1;
					state <= S_OPER;
				end else begin
					busy_out <= 1'b0;
					done_out <= 1'b1;
					instr_len_out <= words;
					next_pc_out <= pc_r;
					state <= S_IDLE;
				end
			end
			default: begin
				state <= S_IDLE;
			end
			endcase
		end
	end

	// source-operand formats: dual, 3/4/9 and single-operand program control
	function instr_is_operand;
		input [15:0] w;
		begin
			instr_is_operand = (w[15:14] != 2'h0) || (w[15:13] == `OAD_FMT39_TOP) ||
				(w[15:10] == `OAD_FMT6_TOP);
		end
	endfunction
endmodule

// ===== hw/oad_regs.vh
// constants for the operand address decoder
`ifndef OAD_REGS_VH
`define OAD_REGS_VH
`define OAD_MODE_DIRECT 2'h0
`define OAD_MODE_INDIRECT 2'h1
`define OAD_MODE_SYMBOLIC 2'h2
`define OAD_MODE_AUTOINC 2'h3
`define OAD_OPC_HI 15
`define OAD_OPC_LO 13
`define OAD_BYTE_BIT 12
`define OAD_TD_HI 11
`define OAD_TD_LO 10
`define OAD_DR_HI 9
`define OAD_DR_LO 6
`define OAD_TS_HI 5
`define OAD_TS_LO 4
`define OAD_SR_HI 3
`define OAD_SR_LO 0
`define OAD_MOVE_OPC 3'h6
`define OAD_WORD_STEP 16'h0002
`define OAD_BYTE_STEP 16'h0001
`define OAD_JUMP_TOP 4'h1
`define OAD_FMT39_TOP 3'h1
`define OAD_FMT4_TOP 6'h0C
`define OAD_FMT5_TOP 8'h08
`define OAD_FMT6_TOP 6'h01
`define OAD_SHIFT_CNT_HI 7
`define OAD_SHIFT_CNT_LO 4
`define OAD_CRU_CNT_HI 9
`define OAD_CRU_CNT_LO 6
`define OAD_IBUF_AW 2
`endif

// ===== hw/oad_ibuf.v
// small instruction word buffer with registered read
`timescale 1ns/10ps
module oad_ibuf (
	input wire sys_clk_in,
	input wire wr_en_in,
	input wire [1:0] wr_idx_in,
	input wire [15:0] wr_data_in,
	input wire [1:0] rd_idx_in,
	output reg [15:0] rd_data_out
);
	reg [15:0] mem [0:3];
	always @(posedge sys_clk_in) begin
		if (wr_en_in) begin
			mem[wr_idx_in] <= wr_data_in;
		end
		rd_data_out <= mem[rd_idx_in];
	end
endmodule

// ===== bench/oad_decoder_asserts.sv
// assertion checker for the operand address decoder
`timescale 1ns/10ps
module oad_decoder_chk (
	input wire sys_clk_in,
	input wire rst_in,
	input wire start_in,
	input wire [15:0] pc_in,
	input wire [15:0] wp_in,
	input wire mem_ack_in,
	input wire [15:0] mem_rdata_in,
	input wire mem_req_out,
	input wire mem_we_out,
	input wire busy_out,
	input wire [15:0] mem_addr_out,
	input wire [15:0] mem_wdata_out,
	input wire done_out,
	input wire [15:0] instr_out,
	input wire byte_op_out,
	input wire move_word_op_out,
	input wire [1:0] src_mode_out,
	input wire [3:0] source_reg_field_out,
	input wire [1:0] dst_mode_out,
	input wire [3:0] dest_reg_field_out,
	input wire src_valid_out,
	input wire [15:0] src_ea_out,
	input wire [15:0] jump_target_out,
	input wire [3:0] count_out,
	input wire [15:0] next_pc_out
);
	wire [15:0] i = instr_out;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	sequence s_take;
		start_in && !busy_out && !done_out;
	endsequence
	sequence s_fetch;
		mem_req_out && !mem_we_out && mem_addr_out == $past(pc_in);
	endsequence
	property p_fetch; s_take |=> s_fetch; endproperty
	a_fetch: assert property (p_fetch) else $error("no fetch at pc");
	property p_byte; done_out |-> byte_op_out == i[12]; endproperty
	a_byte: assert property (p_byte) else $error("byte flag");
	property p_modes; done_out |-> src_mode_out == i[5:4] && dst_mode_out == i[11:10];
	endproperty
	a_modes: assert property (p_modes) else $error("mode fields");
	property p_regs;
		done_out |-> source_reg_field_out == i[3:0] && dest_reg_field_out == i[9:6];
	endproperty
	a_regs: assert property (p_regs) else $error("register fields");
	property p_move; done_out |-> move_word_op_out == (i[15:13] == 3'h6 && !i[12]);
	endproperty
	a_move: assert property (p_move) else $error("move decode");
	property p_direct; done_out && src_valid_out && src_mode_out == 2'h0 |->
		src_ea_out == wp_in + {11'h000, source_reg_field_out, 1'b0}; endproperty
	a_direct: assert property (p_direct) else $error("direct address");
	property p_even; done_out && src_valid_out && !byte_op_out |-> !src_ea_out[0];
	endproperty
	a_even: assert property (p_even) else $error("odd word address");
	property p_jump; done_out && i[15:12] == 4'h1 |->
		jump_target_out == next_pc_out + {{7{i[7]}}, i[7:0], 1'b0}; endproperty
	a_jump: assert property (p_jump) else $error("jump target");
	property p_count; done_out && i[15:10] == 6'h02 |-> count_out == i[7:4]; endproperty
	a_count: assert property (p_count) else $error("shift count");
	property p_inc; $rose(mem_we_out) |-> $past(mem_ack_in) &&
		mem_addr_out == $past(mem_addr_out) &&
		mem_wdata_out == $past(mem_rdata_in) + (byte_op_out ? 16'h0001 : 16'h0002);
	endproperty
	a_inc: assert property (p_inc) else $error("autoincrement write");
endmodule
bind oad_decoder oad_decoder_chk chk_u (
	.sys_clk_in(sys_clk_in),
	.rst_in(rst_in),
	.start_in(start_in),
	.pc_in(pc_in),
	.wp_in(wp_in),
	.mem_ack_in(mem_ack_in),
	.mem_rdata_in(mem_rdata_in),
	.mem_req_out(mem_req_out),
	.mem_we_out(mem_we_out),
	.busy_out(busy_out),
	.mem_addr_out(mem_addr_out),
	.mem_wdata_out(mem_wdata_out),
	.done_out(done_out),
	.instr_out(instr_out),
	.byte_op_out(byte_op_out),
	.move_word_op_out(move_word_op_out),
	.src_mode_out(src_mode_out),
	.source_reg_field_out(source_reg_field_out),
	.dst_mode_out(dst_mode_out),
	.dest_reg_field_out(dest_reg_field_out),
	.src_valid_out(src_valid_out),
	.src_ea_out(src_ea_out),
	.jump_target_out(jump_target_out),
	.count_out(count_out),
	.next_pc_out(next_pc_out)
);

// ===== bench/oad_mem_model.sv
// memory partner: instruction, extension and workspace words
`timescale 1ns/10ps
module oad_mem_model (
	input wire sys_clk_in,
	input wire slow_in,
	input wire req_in,
	input wire we_in,
	input wire [15:0] addr_in,
	input wire [15:0] wdata_in,
	output reg ack_out = 1'b0,
	output reg [15:0] rdata_out = 16'h0000
);
	reg [15:0] mem [0:32767];
	reg [1:0] wait_cnt = 2'h0;
	// data only valid with ack; toggling elsewhere exposes late sampling
	always @(posedge sys_clk_in) begin
		ack_out <= 1'b0;
		rdata_out <= ~rdata_out;
		if (req_in && !ack_out) begin
			if (slow_in && wait_cnt != 2'h3) begin
				wait_cnt <= wait_cnt + 2'h1;
			end else begin
				wait_cnt <= 2'h0;
				ack_out <= 1'b1;
				if (we_in)
					mem[addr_in[15:1]] <= wdata_in;
				else
					rdata_out <= mem[addr_in[15:1]];
			end
		end
	end
endmodule

// ===== bench/oad_decoder_bench.sv
// testbench for the operand address decoder
`timescale 1ns/10ps
module oad_decoder_bench;
	reg sys_clk_in = 0, rst_in = 1, start_in = 0, slow = 0;
	reg [15:0] pc_in = 16'h0000, wp_in = 16'hFC00;
	wire ack, req, we, done, bop, mv, sv, dv;
	wire [15:0] rd, addr, wd, sea, dea, jt, npc, ins;
	wire [1:0] len;
	wire [3:0] cnt;
	integer err_count = 0, tests_run = 0;
	always #4 sys_clk_in = ~sys_clk_in;
	oad_decoder dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .start_in(start_in),
		.pc_in(pc_in), .wp_in(wp_in), .mem_ack_in(ack), .mem_rdata_in(rd),
		.mem_req_out(req), .mem_we_out(we), .mem_addr_out(addr), .mem_wdata_out(wd),
		.busy_out(), .done_out(done), .instr_out(ins), .instr_len_out(len),
		.byte_op_out(bop), .move_word_op_out(mv), .src_mode_out(), .dst_mode_out(),
		.source_reg_field_out(), .dest_reg_field_out(), .src_valid_out(sv),
		.dst_valid_out(dv), .src_ea_out(sea), .dst_ea_out(dea), .jump_target_out(jt),
		.count_out(cnt), .next_pc_out(npc));
	oad_mem_model mem_u (.sys_clk_in(sys_clk_in), .slow_in(slow), .req_in(req),
		.we_in(we), .addr_in(addr), .wdata_in(wd), .ack_out(ack), .rdata_out(rd));
	task chk(input [15:0] seen, input [15:0] exp);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task tally_and_finish;
		begin
			$display("comparisons %0d mismatches %0d", tests_run, err_count);
			if (err_count == 0 && tests_run > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	task put(input [15:0] a, input [15:0] v);
		mem_u.mem[a[15:1]] = v;
	endtask
	task run(input [15:0] pc, input [15:0] wp);
		integer n;
		begin
			@(posedge sys_clk_in);
			pc_in <= pc;
			wp_in <= wp;
			start_in <= 1'b1;
			@(posedge sys_clk_in);
			start_in <= 1'b0;
			n = 0;
			do begin
				@(posedge sys_clk_in);
				#1;
				n = n + 1;
			end while (done !== 1'b1 && n < 300);
			if (done !== 1'b1) begin
				err_count = err_count + 1;
				tally_and_finish;
			end
		end
	endtask
	task t_direct;
		begin
			put(16'h0100, 16'hC101);
			run(16'h0100, 16'hFC00);
			chk(sea, 16'hFC02);
			chk(dea, 16'hFC08);
			chk({15'h0000, mv}, 16'h0001);
			chk({14'h0000, len}, 16'h0001);
			chk(ins, 16'hC101);
			chk({14'h0000, sv, dv}, 16'h0003);
			$display("direct register test done");
		end
	endtask
	task t_auto;
		begin
			slow = 1'b1;
			put(16'h0110, 16'hDD01);
			put(16'hFC08, 16'hFD01);
			run(16'h0110, 16'hFC00);
			chk(dea, 16'hFD01);
			chk(mem_u.mem[16'h7E04], 16'hFD02);
			chk(sea, 16'hFC02);
			chk({15'h0000, bop}, 16'h0001);
			put(16'h0112, 16'hC133);
			put(16'hFC06, 16'hFD04);
			run(16'h0112, 16'hFC00);
			chk(sea, 16'hFD04);
			chk(mem_u.mem[16'h7E03], 16'hFD06);
			slow = 1'b0;
			$display("autoincrement test done");
		end
	endtask
	task t_sym;
		begin
			put(16'h0120, 16'hC820);
			put(16'h0122, 16'hFF0A);
			put(16'h0124, 16'hFF08);
			run(16'h0120, 16'hFC00);
			chk(sea, 16'hFF0A);
			chk(dea, 16'hFF08);
			chk(npc, 16'h0126);
			chk({14'h0000, len}, 16'h0003);
			put(16'h0130, 16'hC860);
			put(16'h0132, 16'hFF00);
			put(16'h0134, 16'hFF02);
			put(16'hF802, 16'h0004);
			run(16'h0130, 16'hF800);
			chk(sea, 16'hFF00);
			chk(dea, 16'hFF06);
			put(16'h0136, 16'hC195);
			put(16'hF80A, 16'hFE03);
			run(16'h0136, 16'hF800);
			chk(sea, 16'hFE02);
			chk(dea, 16'hF80C);
			$display("symbolic and indirect test done");
		end
	endtask
	task t_jump;
		begin
			put(16'h0140, 16'h10FD);
			run(16'h0140, 16'hFC00);
			chk(jt, 16'h013C);
			chk({14'h0000, sv, dv}, 16'h0000);
			put(16'h0142, 16'h0A52);
			run(16'h0142, 16'hFC00);
			chk({12'h000, cnt}, 16'h0005);
			put(16'h0144, 16'h3240);
			run(16'h0144, 16'hFC00);
			chk({12'h000, cnt}, 16'h0009);
			chk(sea, 16'hFC00);
			put(16'h0146, 16'h04C2);
			run(16'h0146, 16'hFC00);
			chk(sea, 16'hFC04);
			chk({14'h0000, sv, dv}, 16'h0002);
			$display("jump and count test done");
		end
	endtask
	initial begin
		repeat (10) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		t_direct;
		t_auto;
		t_sym;
		t_jump;
		tally_and_finish;
	end
endmodule
